// >>> hw/smf_link_if.sv
// interface: packet word and byte events between core and spi link logic
`timescale 1ns/1ps
interface smf_link_if;
  logic [smf_pkg::PKT_W-1:0] word;
  logic edge_rise;
  logic byte_tgl;
  modport core (output word, output edge_rise, input byte_tgl);
  modport link (input word, input edge_rise, output byte_tgl);
endinterface

// >>> hw/smf_pkg.sv
// package: constants and state types of the sensor measure/fetch interface
package smf_pkg;

  // ==========================================================
  // clocking and response times
  localparam int CLK_MHZ = 125;
  // typical sleep-mode response times in microseconds
  localparam int RD_NORM_1M_US = 4500;
  localparam int RD_NORM_4M_US = 1500;
  localparam int WR_NORM_1M_US = 1500;
  localparam int WR_NORM_4M_US = 500;
  localparam int RD_LONG_1M_US = 12000;
  localparam int RD_LONG_4M_US = 4500;
  localparam int WR_LONG_1M_US = 5500;
  localparam int WR_LONG_4M_US = 1500;
  localparam int CNT_W = 24;
  typedef logic [CNT_W-1:0] smf_cnt_t;

  // least select-low time of an spi wake request, rounded up
  localparam int SS_WAKE_NS = 8000;
  localparam int WAKE_W = 11;
  localparam logic [WAKE_W-1:0] SS_WAKE_CYC =
    WAKE_W'((SS_WAKE_NS * CLK_MHZ + 999) / 1000);

  // ==========================================================
  // status codes and packet layout
  localparam logic [1:0] STAT_VALID = 2'h0;
  localparam logic [1:0] STAT_STALE = 2'h2;
  localparam int BRIDGE_W = 14;
  localparam int TEMP_W = 11;
  localparam int PKT_W = 32;
  localparam int PKT_STAT_LSB = 30;
  localparam logic [4:0] PKT_MSB = 5'h1F;
  localparam logic [4:0] PKT_PAD = 5'h00;

  // ==========================================================
  // link framing
  localparam logic [3:0] BIT_END = 4'h8;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [2:0] BYTE_SAT = 3'h7;
  localparam logic [2:0] FETCH_MIN_BYTES = 3'h2;
  localparam logic [2:0] CMD_BYTES = 3'h3;
  localparam logic [6:0] I2C_ADDR_DEF = 7'h3C;
  // spi edge select sits in bit 0 of configuration word 02h
  localparam int SPI_POL_BIT = 0;
  localparam logic [7:0] SPI_CFG_WORD = 8'h02;
  // idle levels of the synchronised pins: tgl, ss, sda, scl
  localparam logic [3:0] SYNC_INIT = 4'h7;

  // ==========================================================
  // state types
  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_AACK = 3'b010,
    I_TX = 3'b011,
    I_TACK = 3'b100,
    I_RX = 3'b101,
    I_RACK = 3'b110
  } smf_i2c_st_t;

  typedef enum logic {
    M_SLEEP = 1'b0,
    M_RUN = 1'b1
  } smf_meas_st_t;

endpackage

// >>> hw/smf_spi_link.sv
// module: spi shifter running on the master's serial clock
`timescale 1ns/1ps
module smf_spi_link (
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic rst,
  smf_link_if.link lnk,
  output logic miso
);

  // ==========================================================
  // edge select synchroniser; the setting is static in use
  logic edge_a;
  logic edge_s;
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      edge_a <= 1'b0;
      edge_s <= 1'b0;
    end else begin
      edge_a <= lnk.edge_rise;
      edge_s <= edge_a;
    end
  end

  // ==========================================================
  // bit counters; select high ends the frame, sclk may stop
  logic [4:0] rise_cnt;
  logic [4:0] fall_cnt;
  always_ff @(posedge sclk or posedge ss_n or posedge rst) begin
    if (ss_n || rst) begin
      rise_cnt <= 5'h00;
    end else begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end

  always_ff @(negedge sclk or posedge ss_n or posedge rst) begin
    if (ss_n || rst) begin
      fall_cnt <= 5'h00;
    end else begin
      fall_cnt <= fall_cnt + 5'h01;
    end
  end

  // toggle per finished byte, so the core sees an event, not a level
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      lnk.byte_tgl <= 1'b0;
    end else if (!ss_n && rise_cnt[2:0] == smf_pkg::BYTE_LAST_BIT) begin
      lnk.byte_tgl <= ~lnk.byte_tgl;
    end
  end

  // rising mode: the master samples on the fall, so the bit sent after
  // rise k must be bit k-1; the index trails the rise count by one
  logic [4:0] bit_sel;
  always_comb begin
    bit_sel = fall_cnt;
    if (edge_s) begin
      bit_sel = (rise_cnt == 5'h00 && fall_cnt == 5'h00) ? 5'h00
                : rise_cnt - 5'h01;
    end
  end

  // msb first; bit moves on the selected edge
  assign miso = lnk.word[smf_pkg::PKT_MSB - bit_sel];

  property p_first_bit;
    @(posedge sclk) disable iff (ss_n || rst)
      (rise_cnt == 5'h00 && fall_cnt == 5'h00) |->
        miso == lnk.word[smf_pkg::PKT_W-1];
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("bad first bit");

endmodule

// >>> hw/smf_top.sv
// module: sleep-mode measure and fetch readout core with i2c and spi
// Function
// - fetch returns last valid result, then status turns stale
// - fetch during a running measurement returns stale status
// - normal integration response times per clock and request kind
// - long integration response times per clock and request kind
// - output invalid from reset until first result is written
// - in i2c mode the shared pin rises when new data is ready
// - i2c read addresses seven bits plus read bit; device acknowledges
// - bare i2c read then stop starts a full measurement cycle
// - i2c fetch sends bytes until master nacks and stops
// - packet: two bridge bytes with status msbs, temperature bytes
// - spi output edge selectable, falling edge by default
// - select low at least 8us then high wakes full cycle
// - falling mode: miso changes after falling, sampled on rising
// - spi packet 32 bits msb first; master may stop early
// - bare i2c write wakes bridge-only measurement with stored values
// - full i2c write in sleep counts as wake-by-write
// - command writes: address, command byte, sixteen-bit data
`timescale 1ns/1ps
module smf_top #(
  parameter smf_pkg::smf_cnt_t RD_NORM_1M_CYC =
    smf_pkg::smf_cnt_t'(smf_pkg::RD_NORM_1M_US * smf_pkg::CLK_MHZ),
  parameter smf_pkg::smf_cnt_t RD_NORM_4M_CYC =
    smf_pkg::smf_cnt_t'(smf_pkg::RD_NORM_4M_US * smf_pkg::CLK_MHZ),
  parameter smf_pkg::smf_cnt_t WR_NORM_1M_CYC =
    smf_pkg::smf_cnt_t'(smf_pkg::WR_NORM_1M_US * smf_pkg::CLK_MHZ),
  parameter smf_pkg::smf_cnt_t WR_NORM_4M_CYC =
    smf_pkg::smf_cnt_t'(smf_pkg::WR_NORM_4M_US * smf_pkg::CLK_MHZ),
  parameter smf_pkg::smf_cnt_t RD_LONG_1M_CYC =
    smf_pkg::smf_cnt_t'(smf_pkg::RD_LONG_1M_US * smf_pkg::CLK_MHZ),
  parameter smf_pkg::smf_cnt_t RD_LONG_4M_CYC =
    smf_pkg::smf_cnt_t'(smf_pkg::RD_LONG_4M_US * smf_pkg::CLK_MHZ),
  parameter smf_pkg::smf_cnt_t WR_LONG_1M_CYC =
    smf_pkg::smf_cnt_t'(smf_pkg::WR_LONG_1M_US * smf_pkg::CLK_MHZ),
  parameter smf_pkg::smf_cnt_t WR_LONG_4M_CYC =
    smf_pkg::smf_cnt_t'(smf_pkg::WR_LONG_4M_US * smf_pkg::CLK_MHZ),
  parameter logic [6:0] I2C_ADDR = smf_pkg::I2C_ADDR_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_mode,
  input wire logic spi_edge_rise,
  input wire logic clk_4mhz_sel,
  input wire logic long_integ,
  input wire logic cmd_mode,
  input wire logic [smf_pkg::BRIDGE_W-1:0] bridge_in,
  input wire logic [smf_pkg::TEMP_W-1:0] temp_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic sclk,
  input wire logic ss_int_in,
  output logic ss_int_out,
  output logic ss_int_oe_n,
  output logic miso,
  output logic miso_oe_n,
  output logic busy,
  output logic meas_full,
  output logic data_ready,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_data
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // pin synchronisers; stage a is read by stage b only
  localparam int NSYNC = 4;
  smf_link_if lnk ();
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_c;
  assign pin_raw = {lnk.byte_tgl, ss_int_in, sda_in, scl_in};

  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        sync_a[g] <= smf_pkg::SYNC_INIT[g];
        sync_b[g] <= smf_pkg::SYNC_INIT[g];
        sync_c[g] <= smf_pkg::SYNC_INIT[g];
      end else begin
        sync_a[g] <= pin_raw[g];
        sync_b[g] <= sync_a[g];
        sync_c[g] <= sync_b[g];
      end
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  logic ss_rise;
  logic tgl_edge;
  assign scl_rise = sync_b[0] & ~sync_c[0];
  assign scl_fall = ~sync_b[0] & sync_c[0];
  assign i2c_start = sync_b[0] & sync_c[0] & sync_c[1] & ~sync_b[1];
  assign i2c_stop = sync_b[0] & sync_c[0] & ~sync_c[1] & sync_b[1];
  assign ss_rise = sync_b[2] & ~sync_c[2];
  assign tgl_edge = sync_b[3] ^ sync_c[3];

  // ==========================================================
  // result registers and packet
  smf_pkg::smf_meas_st_t m_st;
  logic [1:0] status;
  logic [smf_pkg::BRIDGE_W-1:0] res_bridge;
  logic [smf_pkg::TEMP_W-1:0] res_temp;
  logic [smf_pkg::PKT_W-1:0] pkt_live;
  logic [smf_pkg::PKT_W-1:0] pkt_hold;
  logic meas_done;
  logic fetch_done;
  logic wake_rd;
  logic wake_wr;
  logic frame;
  smf_pkg::smf_i2c_st_t i_st;

  // status is forced stale while a cycle runs
  assign pkt_live = {busy ? smf_pkg::STAT_STALE : status, res_bridge,
                     res_temp, smf_pkg::PKT_PAD};
  assign frame = spi_mode ? ~sync_b[2] : (i_st != smf_pkg::I_IDLE);

  // freeze the packet for a whole transfer so bytes never tear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pkt_hold <= '0;
    end else if (!frame) begin
      pkt_hold <= pkt_live;
    end
  end

  // packet byte i, most significant first
  function automatic logic [7:0] pkt_byte(
    input logic [smf_pkg::PKT_W-1:0] w,
    input logic [1:0] i
  );
    pkt_byte = w[{~i, 3'b000} +: 8];
  endfunction

  // ==========================================================
  // i2c slave
  logic [3:0] bitc;
  logic [7:0] sh;
  logic [7:0] txsh;
  logic [2:0] nbytes;
  logic [2:0] nbytes_inc;
  logic is_rd;
  logic addressed;
  logic i2c_wake_rd;
  logic i2c_wake_wr;
  logic i2c_fetch;
  assign nbytes_inc = (nbytes == smf_pkg::BYTE_SAT) ? nbytes
                      : nbytes + 3'h1;

  // protocol engine; stop decides what the transfer meant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i_st <= smf_pkg::I_IDLE;
      bitc <= 4'h0;
      sh <= 8'h00;
      txsh <= 8'h00;
      nbytes <= 3'h0;
      is_rd <= 1'b0;
      addressed <= 1'b0;
      i2c_wake_rd <= 1'b0;
      i2c_wake_wr <= 1'b0;
      i2c_fetch <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_code <= 8'h00;
      cmd_data <= 16'h0000;
    end else begin
      i2c_wake_rd <= 1'b0;
      i2c_wake_wr <= 1'b0;
      i2c_fetch <= 1'b0;
      cmd_valid <= 1'b0;
      if (spi_mode) begin
        i_st <= smf_pkg::I_IDLE;
        addressed <= 1'b0;
      end else if (i2c_start) begin
        i_st <= smf_pkg::I_ADDR;
        bitc <= 4'h0;
        nbytes <= 3'h0;
        addressed <= 1'b0;
      end else if (i2c_stop) begin
        i_st <= smf_pkg::I_IDLE;
        addressed <= 1'b0;
        if (addressed && is_rd && nbytes == 3'h0) begin
          i2c_wake_rd <= 1'b1;
        end else if (addressed && is_rd
                     && nbytes >= smf_pkg::FETCH_MIN_BYTES) begin
          i2c_fetch <= 1'b1;
        end else if (addressed && !is_rd && cmd_mode
                     && nbytes == smf_pkg::CMD_BYTES) begin
          cmd_valid <= 1'b1;
        end else if (addressed && !is_rd && !cmd_mode) begin
          i2c_wake_wr <= 1'b1; // data bytes are don't-care
        end
      end else begin
        unique case (i_st)
          smf_pkg::I_IDLE: begin
          end
          smf_pkg::I_ADDR: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sync_b[1]};
              bitc <= bitc + 4'h1;
            end else if (scl_fall && bitc == smf_pkg::BIT_END) begin
              if (sh[7:1] == I2C_ADDR) begin
                i_st <= smf_pkg::I_AACK;
                is_rd <= sh[0];
                addressed <= 1'b1;
              end else begin
                i_st <= smf_pkg::I_IDLE;
              end
            end
          end
          smf_pkg::I_AACK: begin
            if (scl_fall) begin
              bitc <= 4'h0;
              if (is_rd) begin
                i_st <= smf_pkg::I_TX;
                txsh <= pkt_byte(pkt_hold, nbytes[1:0]);
              end else begin
                i_st <= smf_pkg::I_RX;
              end
            end
          end
          smf_pkg::I_TX: begin
            if (scl_rise) begin
              bitc <= bitc + 4'h1;
            end else if (scl_fall) begin
              if (bitc == smf_pkg::BIT_END) begin
                i_st <= smf_pkg::I_TACK;
              end else begin
                txsh <= {txsh[6:0], 1'b0};
              end
            end
          end
          smf_pkg::I_TACK: begin
            if (scl_rise) begin
              nbytes <= nbytes_inc;
              if (sync_b[1]) begin
                i_st <= smf_pkg::I_IDLE; // nack ends the packet
              end
            end else if (scl_fall) begin
              i_st <= smf_pkg::I_TX;
              bitc <= 4'h0;
              txsh <= pkt_byte(pkt_hold, nbytes[1:0]);
            end
          end
          smf_pkg::I_RX: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sync_b[1]};
              bitc <= bitc + 4'h1;
            end else if (scl_fall && bitc == smf_pkg::BIT_END) begin
              i_st <= smf_pkg::I_RACK;
              nbytes <= nbytes_inc;
              // command byte then sixteen data bits, high first
              if (nbytes == 3'h0) begin
                cmd_code <= sh;
              end else if (nbytes == 3'h1) begin
                cmd_data[15:8] <= sh;
              end else if (nbytes == 3'h2) begin
                cmd_data[7:0] <= sh;
              end
            end
          end
          smf_pkg::I_RACK: begin
            if (scl_fall) begin
              i_st <= smf_pkg::I_RX;
              bitc <= 4'h0;
            end
          end
          default: begin
            i_st <= smf_pkg::I_IDLE;
          end
        endcase
      end
    end
  end

  // open-drain data: pull low for acks and zero data bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_oe_n <= 1'b1;
    end else begin
      sda_oe_n <= ~(i_st == smf_pkg::I_AACK || i_st == smf_pkg::I_RACK
                    || (i_st == smf_pkg::I_TX && !txsh[7]));
    end
  end
  assign sda_out = 1'b0;

  // ==========================================================
  // spi framing in the core domain
  logic [smf_pkg::WAKE_W-1:0] ss_low;
  logic [2:0] spi_bytes;
  logic spi_wake;
  logic spi_fetch;

  // low time and byte count decide wake versus fetch at select rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ss_low <= '0;
      spi_bytes <= 3'h0;
      spi_wake <= 1'b0;
      spi_fetch <= 1'b0;
    end else begin
      spi_wake <= 1'b0;
      spi_fetch <= 1'b0;
      if (!spi_mode) begin
        ss_low <= '0;
        spi_bytes <= 3'h0;
      end else if (!sync_b[2]) begin
        if (ss_low != smf_pkg::SS_WAKE_CYC) begin
          ss_low <= ss_low + 1'b1;
        end
        if (tgl_edge && spi_bytes != smf_pkg::BYTE_SAT) begin
          spi_bytes <= spi_bytes + 3'h1;
        end
      end else if (ss_rise) begin
        spi_fetch <= (spi_bytes >= smf_pkg::FETCH_MIN_BYTES);
        spi_wake <= (spi_bytes == 3'h0)
                    && (ss_low == smf_pkg::SS_WAKE_CYC);
      end else begin
        ss_low <= '0;
        spi_bytes <= 3'h0;
      end
    end
  end

  assign lnk.word = pkt_hold;
  assign lnk.edge_rise = spi_edge_rise;

  smf_spi_link u_link (
    .sclk(sclk),
    .ss_n(ss_int_in),
    .rst(rst),
    .lnk(lnk.link),
    .miso(miso)
  );
  assign miso_oe_n = ~(spi_mode & ~ss_int_in);

  // ==========================================================
  // measurement sequencer
  smf_pkg::smf_cnt_t cnt;
  logic long_q;
  logic fast_q;
  assign wake_rd = i2c_wake_rd | spi_wake;
  assign wake_wr = i2c_wake_wr;
  assign fetch_done = i2c_fetch | spi_fetch;
  assign busy = (m_st == smf_pkg::M_RUN);
  assign meas_done = busy && cnt == smf_pkg::smf_cnt_t'(1);

  function automatic smf_pkg::smf_cnt_t resp_cycles(
    input logic full,
    input logic lng,
    input logic fast
  );
    unique case ({full, lng, fast})
      3'b100: resp_cycles = RD_NORM_1M_CYC;
      3'b101: resp_cycles = RD_NORM_4M_CYC;
      3'b000: resp_cycles = WR_NORM_1M_CYC;
      3'b001: resp_cycles = WR_NORM_4M_CYC;
      3'b110: resp_cycles = RD_LONG_1M_CYC;
      3'b111: resp_cycles = RD_LONG_4M_CYC;
      3'b010: resp_cycles = WR_LONG_1M_CYC;
      3'b011: resp_cycles = WR_LONG_4M_CYC;
    endcase
  endfunction

  // requests wake only from sleep; fetches never wake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m_st <= smf_pkg::M_SLEEP;
      cnt <= '0;
      meas_full <= 1'b0;
      long_q <= 1'b0;
      fast_q <= 1'b0;
    end else begin
      unique case (m_st)
        smf_pkg::M_SLEEP: begin
          if (wake_rd || wake_wr) begin
            m_st <= smf_pkg::M_RUN;
            meas_full <= wake_rd;
            long_q <= long_integ;
            fast_q <= clk_4mhz_sel;
            cnt <= resp_cycles(wake_rd, long_integ, clk_4mhz_sel);
          end
        end
        smf_pkg::M_RUN: begin
          if (meas_done) begin
            m_st <= smf_pkg::M_SLEEP;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // result write wins over a fetch in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_bridge <= '0;
      res_temp <= '0;
      status <= smf_pkg::STAT_STALE;
      data_ready <= 1'b0;
      ss_int_out <= 1'b0;
    end else if (meas_done) begin
      res_bridge <= bridge_in;
      if (meas_full) begin
        res_temp <= temp_in; // bridge-only keeps stored temperature
      end
      status <= smf_pkg::STAT_VALID;
      data_ready <= 1'b1;
      ss_int_out <= 1'b1;
    end else if (fetch_done) begin
      status <= smf_pkg::STAT_STALE;
      ss_int_out <= 1'b0;
    end
  end
  assign ss_int_oe_n = spi_mode; // pin is an interrupt only in i2c mode

  // ==========================================================
  // checks
  logic [smf_pkg::CNT_W-1:0] run_len;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_len <= '0;
    end else begin
      run_len <= busy ? run_len + 1'b1 : '0;
    end
  end

  sequence s_addr_hit;
    !spi_mode && !i2c_start && !i2c_stop && i_st == smf_pkg::I_ADDR
      && scl_fall && bitc == smf_pkg::BIT_END && sh[7:1] == I2C_ADDR;
  endsequence
  sequence s_ss_wake;
    spi_mode && ss_rise && spi_bytes == 3'h0
      && ss_low == smf_pkg::SS_WAKE_CYC;
  endsequence

  property p_fetch_stale;
    fetch_done && !meas_done |=> status == smf_pkg::STAT_STALE;
  endproperty
  property p_busy_stale;
    busy |-> pkt_live[smf_pkg::PKT_STAT_LSB +: 2] == smf_pkg::STAT_STALE;
  endproperty
  property p_resp_norm;
    meas_done && !long_q |-> run_len == (meas_full
      ? (fast_q ? RD_NORM_4M_CYC : RD_NORM_1M_CYC)
      : (fast_q ? WR_NORM_4M_CYC : WR_NORM_1M_CYC)) - 1'b1;
  endproperty
  property p_resp_long;
    meas_done && long_q |-> run_len == (meas_full
      ? (fast_q ? RD_LONG_4M_CYC : RD_LONG_1M_CYC)
      : (fast_q ? WR_LONG_4M_CYC : WR_LONG_1M_CYC)) - 1'b1;
  endproperty
  property p_first_valid;
    !data_ready |-> status == smf_pkg::STAT_STALE && !ss_int_out;
  endproperty
  property p_int_rise;
    meas_done && !spi_mode |=> ss_int_out && !ss_int_oe_n;
  endproperty
  property p_addr_ack;
    s_addr_hit |-> ##2 !sda_oe_n;
  endproperty
  property p_wake_rd;
    i2c_wake_rd && !busy |=> busy && meas_full;
  endproperty
  property p_wake_wr;
    i2c_wake_wr && !wake_rd && !busy |=> busy && !meas_full;
  endproperty
  property p_tx_first;
    i_st == smf_pkg::I_AACK && is_rd && scl_fall && !i2c_stop
      && !i2c_start && !spi_mode && nbytes == 3'h0
      |=> txsh == pkt_hold[smf_pkg::PKT_W-1 -: 8];
  endproperty
  property p_spi_wake;
    s_ss_wake ##1 !busy |=> busy && meas_full;
  endproperty

  a_fetch_stale: assert property (p_fetch_stale) else $error("not stale");
  a_busy_stale: assert property (p_busy_stale) else $error("busy valid");
  a_resp_norm: assert property (p_resp_norm) else $error("norm time");
  a_resp_long: assert property (p_resp_long) else $error("long time");
  a_first_valid: assert property (p_first_valid) else $error("early");
  a_int_rise: assert property (p_int_rise) else $error("no int");
  a_addr_ack: assert property (p_addr_ack) else $error("no ack");
  a_wake_rd: assert property (p_wake_rd) else $error("no read wake");
  a_tx_first: assert property (p_tx_first) else $error("bad byte");
  a_spi_wake: assert property (p_spi_wake) else $error("no spi wake");
  a_wake_wr: assert property (p_wake_wr) else $error("no wr wake");

endmodule

// >>> sim/smf_host_model.sv
// partner: spi bus master model that wakes and fetches
`timescale 1ns/1ps
module smf_host_model (
  input wire logic miso,
  input wire logic edge_rise,
  output logic ss_n,
  output logic sclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  logic [31:0] rx;
  int acks;
  // ==========================================================
  // sclk only toggles inside frames and idles low between them
  initial begin
    ss_n = 1'b1;
    sclk = 1'b0;
    rx = '0;
    scl = 1'b1;
    sda_drv = 1'b1;
    acks = 0;
  end
  // bus free 2 us, select low, nbits at 160 ns, select high
  task automatic frame(input int nbits, input int low_ns);
    rx = '0;
    #2000 ss_n = 1'b0;
    #(low_ns);
    repeat (nbits) begin
      #80 sclk = 1'b1;
      if (!edge_rise) rx = {rx[30:0], miso};
      #80 sclk = 1'b0;
      if (edge_rise) rx = {rx[30:0], miso};
    end
    #100 ss_n = 1'b1;
  endtask
  // ==========================================================
  // i2c master: data moves only while scl is low, 400 ns per bit
  task automatic i2c_bit(input logic b);
    #100 sda_drv = b;
    #100 scl = 1'b1;
    #200 scl = 1'b0;
  endtask
  // start, nbytes of pkt msb first with acks counted, stop
  task automatic i2c_write(input logic [31:0] pkt, input int nbytes);
    acks = 0;
    #2000 sda_drv = 1'b0; // start
    #200 scl = 1'b0;
    for (int i = 0; i < 8 * nbytes; i++) begin
      i2c_bit(pkt[31 - i]);
      if (i % 8 == 7) begin
        #100 sda_drv = 1'b1;
        #100 scl = 1'b1;
        if (sda_line === 1'b0) acks++;
        #200 scl = 1'b0;
      end
    end
    #100 sda_drv = 1'b0;
    #100 scl = 1'b1;
    #200 sda_drv = 1'b1; // stop
  endtask
endmodule

// >>> sim/test_sensor_measure_fetch_iface.sv
// testbench: spi wake, response time and fetch packet checks
`timescale 1ns/1ps
module test_sensor_measure_fetch_iface;
  // short response counts indexed by {long, 4 MHz}
  localparam int N_RD[4] = '{40, 50, 3000, 70};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic spi_mode = 1'b1;
  logic edge_rise = 1'b0;
  logic fast = 1'b0;
  logic lng = 1'b0;
  logic [13:0] bridge = 14'h0000;
  logic [10:0] temp = 11'h000;
  logic ss_n, sclk, miso, busy, data_ready;
  logic cmd_mode = 1'b0;
  logic scl, sda_drv, sda_oe_n, sda_line, int_oe_n, int_out, meas_full;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [15:0] cmd_data;
  // open-drain data line with its pull-up
  assign sda_line = sda_drv & sda_oe_n;
  int fail_count = 0;
  int check_count = 0;
  // ==========================================================
  // 125 MHz core clock
  always #4 clk = ~clk;
  smf_top #(.RD_NORM_1M_CYC(40), .RD_NORM_4M_CYC(50),
    .RD_LONG_1M_CYC(3000), .RD_LONG_4M_CYC(70)) i_dut (
    .clk(clk), .rst(rst), .spi_mode(spi_mode),
    .spi_edge_rise(edge_rise), .clk_4mhz_sel(fast),
    .long_integ(lng), .cmd_mode(cmd_mode), .bridge_in(bridge),
    .temp_in(temp), .scl_in(scl), .sda_in(sda_line), .sda_out(),
    .sda_oe_n(sda_oe_n), .sclk(sclk), .ss_int_in(ss_n),
    .ss_int_out(int_out), .ss_int_oe_n(int_oe_n), .miso(miso),
    .miso_oe_n(), .busy(busy), .meas_full(meas_full),
    .data_ready(data_ready), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data));
  smf_host_model i_host (.miso(miso), .edge_rise(edge_rise),
    .ss_n(ss_n), .sclk(sclk), .sda_line(sda_line), .scl(scl),
    .sda_drv(sda_drv));
  // ==========================================================
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // expected packet built from what the converter was given
  function automatic logic [31:0] word(input logic [1:0] st);
    return {st, bridge, temp, 5'h00};
  endfunction
  // fetch n bytes; only the leading bytes of the packet arrive
  task automatic fetch(input int n, input logic [1:0] st);
    logic [31:0] exp;
    exp = word(st) >> (32 - 8 * n);
    i_host.frame(8 * n, 100);
    chk("packet", exp, i_host.rx);
  endtask
  // spi wake, then count the cycles that busy stays high
  task automatic wake_time(input int exp_cyc);
    int n;
    n = 0;
    i_host.frame(0, 8200);
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (busy !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    n = 0;
    // bound sits above 1.15 times the longest count
    while (busy === 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk("busy cycles", exp_cyc, n);
    if (n == 4000) print_verdict();
  endtask
  // i2c command write with an all-zero data field, then its outputs
  task automatic i2c_cmd();
    logic [31:0] pkt;
    int n;
    n = 0;
    pkt = {smf_pkg::I2C_ADDR_DEF, 1'b0, 8'hA5, 16'h0000};
    @(posedge clk);
    spi_mode <= 1'b0;
    cmd_mode <= 1'b1;
    i_host.i2c_write(pkt, 4);
    while (cmd_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("cmd valid", 1, cmd_valid);
    chk("cmd word", 32'h00A50000, {cmd_code, cmd_data});
    chk("acks", 4, i_host.acks);
    chk("int drive", 0, int_oe_n);
  endtask
  // ==========================================================
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("ready", 0, data_ready);
    fetch(2, smf_pkg::STAT_STALE);
    // each timing entry, a valid fetch, then a stale refetch
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {lng, fast} <= i[1:0];
      bridge <= 14'h2A5C + 14'(i);
      temp <= 11'h5B3 - 11'(i);
      wake_time(N_RD[i]);
      chk("ready", 1, data_ready);
      chk("full", 1, meas_full);
      chk("int", 1, int_out);
      fetch(4, smf_pkg::STAT_VALID);
      fetch(3, smf_pkg::STAT_STALE);
    end
    // a fetch inside a long measurement reads stale
    @(posedge clk);
    {lng, fast} <= 2'b10;
    i_host.frame(0, 8200);
    fetch(3, smf_pkg::STAT_STALE);
    for (int k = 0; k < 4000 && busy === 1'b1; k++) @(negedge clk);
    chk("idle", 0, busy);
    // rising-edge output mode still delivers the whole packet
    @(posedge clk);
    edge_rise <= 1'b1;
    fetch(4, smf_pkg::STAT_VALID);
    i2c_cmd();
    print_verdict();
  end
endmodule
